// File: src/rss_pkg.sv
// constants shared by the setpoint and sequencing register block
package rss_pkg;
  // ----------
  // register indices (byte address is four times the index)
  // ----------
  localparam logic [7:0] IDX_SETPOINT_A = 8'h06; // first converter setpoint
  localparam logic [7:0] IDX_SETPOINT_B = 8'h07; // second converter setpoint
  localparam logic [7:0] IDX_STEPUP_CTRL = 8'h08; // step-up control
  localparam logic [7:0] IDX_DELAY_A = 8'h09; // first converter delays
  localparam logic [7:0] IDX_DELAY_B = 8'h0a; // second converter delays
  localparam logic [7:0] IDX_FIRST_CTRL = 8'h10; // first converter enable
  localparam logic [7:0] IDX_CONFIG = 8'h11; // delay scale
  localparam logic [7:0] IDX_STATUS = 8'h12; // read-only live state
  // ----------
  // field positions
  // ----------
  localparam int VSEL_HI = 7; // step-up voltage select
  localparam int VSEL_LO = 6;
  localparam int RSV5_BIT = 5; // reserved read-write
  localparam int RSV4_BIT = 4; // reserved read-write
  localparam int RDIS_BIT = 3; // discharge enable
  localparam int PIN_HI = 2; // pin gating select
  localparam int PIN_LO = 1;
  localparam int EN_BIT = 0; // software enable
  localparam int OFF_HI = 7; // shutdown delay code
  localparam int OFF_LO = 4;
  localparam int ON_HI = 3; // startup delay code
  localparam int ON_LO = 0;
  // ----------
  // reset values
  // ----------
  localparam logic [7:0] RST_SETPOINT = 8'h00;
  localparam logic [7:0] RST_STEPUP_CTRL = 8'h08;
  localparam logic [7:0] RST_DELAY = 8'h00;
  localparam logic [7:0] RST_ZERO = 8'h00;
  // ----------
  // setpoint code bands and voltages in millivolts
  // ----------
  localparam logic [7:0] CODE_BAND1 = 8'h14;
  localparam logic [7:0] CODE_BAND1_TOP = 8'h17;
  localparam logic [7:0] CODE_BAND2 = 8'h18;
  localparam logic [7:0] CODE_BAND2_TOP = 8'h9d;
  localparam logic [7:0] CODE_BAND3 = 8'h9e;
  localparam logic [11:0] MV_BAND1 = 12'd700;
  localparam logic [11:0] MV_BAND2 = 12'd735;
  localparam logic [11:0] MV_BAND3 = 12'd1420;
  localparam logic [11:0] STEP_BAND1 = 12'd10;
  localparam logic [11:0] STEP_BAND2 = 12'd5;
  localparam logic [11:0] STEP_BAND3 = 12'd20;
  localparam logic [12:0] MV_STEPUP_BASE = 13'd4900;
  localparam logic [12:0] MV_STEPUP_STEP = 13'd100;
  // ----------
  // timing
  // ----------
  localparam int CLK_KHZ = 40000; // 40 mhz system clock
  localparam int DELAY_UNIT_US = 500; // base delay unit, 0.5 ms
  localparam int UNIT_CYCLES = (DELAY_UNIT_US * CLK_KHZ) / 1000;
  // sequencer states, one-hot
  typedef enum logic [3:0] {
    SEQ_OFF = 4'b0001,
    SEQ_WAIT_ON = 4'b0010,
    SEQ_ON = 4'b0100,
    SEQ_WAIT_OFF = 4'b1000
  } rss_seq_t;
endpackage

// File: src/rss_delay_timer.sv
// startup and shutdown delay sequencer for one converter
`timescale 1ns/1ps
`default_nettype none
module rss_delay_timer (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic tick_in,
  input wire logic ctrl_in,
  input wire logic [3:0] on_code_in,
  input wire logic [3:0] off_code_in,
  input wire logic scale_in,
  output logic enable_out,
  output logic busy_out
);
  // ----------
  // state and tick counter
  // ----------
  rss_pkg::rss_seq_t state_q, state_d; // sequencer state
  logic [4:0] count_q, count_d; // remaining time-base ticks
  wire [4:0] on_ticks = scale_in ? {on_code_in, 1'b0} : {1'b0, on_code_in};
  wire [4:0] off_ticks = scale_in ? {off_code_in, 1'b0} : {1'b0, off_code_in};
  wire last_tick = tick_in && (count_q == 5'h01);

  // next-state logic; a reversal of the control level cancels a wait
  always_comb begin
    state_d = state_q;
    count_d = count_q;
    case (state_q)
      rss_pkg::SEQ_OFF: begin
        if (ctrl_in && on_ticks == 5'h00) begin
          state_d = rss_pkg::SEQ_ON;
        end else if (ctrl_in) begin
          state_d = rss_pkg::SEQ_WAIT_ON;
          count_d = on_ticks;
        end
      end
      rss_pkg::SEQ_WAIT_ON: begin
        if (!ctrl_in) begin
          state_d = rss_pkg::SEQ_OFF;
        end else if (last_tick) begin
          state_d = rss_pkg::SEQ_ON;
        end else if (tick_in) begin
          count_d = count_q - 5'h01;
        end
      end
      rss_pkg::SEQ_ON: begin
        if (!ctrl_in && off_ticks == 5'h00) begin
          state_d = rss_pkg::SEQ_OFF;
        end else if (!ctrl_in) begin
          state_d = rss_pkg::SEQ_WAIT_OFF;
          count_d = off_ticks;
        end
      end
      rss_pkg::SEQ_WAIT_OFF: begin
        if (ctrl_in) begin
          state_d = rss_pkg::SEQ_ON;
        end else if (last_tick) begin
          state_d = rss_pkg::SEQ_OFF;
        end else if (tick_in) begin
          count_d = count_q - 5'h01;
        end
      end
      default: begin
        state_d = rss_pkg::SEQ_OFF;
      end
    endcase
  end

  // state registers
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q <= rss_pkg::SEQ_OFF;
      count_q <= 5'h00;
    end else begin
      state_q <= state_d;
      count_q <= count_d;
    end
  end

  // converter stays on while its shutdown wait runs
  assign enable_out = (state_q == rss_pkg::SEQ_ON) || (state_q == rss_pkg::SEQ_WAIT_OFF);
  assign busy_out = (state_q == rss_pkg::SEQ_WAIT_ON) || (state_q == rss_pkg::SEQ_WAIT_OFF);
endmodule
`default_nettype wire

// File: src/rss_top.sv
// setpoint, step-up control and sequencing registers with apb access
// Function
// - codes 0x14-0x17 give 0.70-0.73 V, 10 mV
// - codes 0x18-0x9d give 0.735-1.4 V, 5 mV
// - codes 0x9e-0xff give 1.42-3.36 V, 20 mV
// - second converter setpoint uses same mapping
// - step-up field selects 4.9 to 5.2 V
// - discharge resistor connected when off and bit set
// - pin field gates step-up with chosen pin
// - bit zero is step-up software enable
// - shutdown delay after control falls, 0.5 ms units
// - startup delay after control rises, zero immediate
// - scale bit doubles delay unit to 1 ms
// - fields except the reserved and discharge bits load one-time-programmable defaults on the first clock after reset release
// - reserved bits 5 and 4, register resets 8h
`timescale 1ns/1ps
`default_nettype none
module rss_top #(
  parameter int UNIT_CYCLES = rss_pkg::UNIT_CYCLES // clocks per 0.5 ms
) (
  input wire logic MCLK_IN,
  input wire logic RESET_N_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  input wire logic [3:0] PSTRB_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  input wire logic ENABLE_PIN_A_IN,
  input wire logic ENABLE_PIN_B_IN,
  input wire logic ENABLE_PIN_C_IN,
  input wire logic [7:0] OTP_SETPOINT_A_IN,
  input wire logic [7:0] OTP_SETPOINT_B_IN,
  input wire logic [1:0] OTP_STEPUP_VSEL_IN,
  input wire logic [1:0] OTP_STEPUP_PIN_IN,
  input wire logic OTP_STEPUP_EN_IN,
  input wire logic [2:0] OTP_FIRST_CTRL_IN,
  input wire logic [7:0] OTP_DELAY_A_IN,
  input wire logic [7:0] OTP_DELAY_B_IN,
  input wire logic OTP_DELAY_SCALE_IN,
  output logic [7:0] FIRST_STEPDOWN_SETPOINT_OUT,
  output logic [7:0] SECOND_STEPDOWN_SETPOINT_OUT,
  output logic [11:0] FIRST_STEPDOWN_MV_OUT,
  output logic [11:0] SECOND_STEPDOWN_MV_OUT,
  output logic [12:0] STEPUP_MV_OUT,
  output logic STEPUP_ENABLE_OUT,
  output logic STEPUP_DISCHARGE_OUT,
  output logic FIRST_STEPDOWN_ENABLE_OUT,
  output logic FIRST_STEPDOWN_DISCHARGE_OUT
);
  // ----------
  // elaboration check
  // ----------
  // at least two clocks per unit, and the unit must fit 16 counter bits
  if (UNIT_CYCLES < 2 || UNIT_CYCLES > 65536) begin : g_bad_unit
    $error("UNIT_CYCLES must lie between 2 and 65536");
  end

  // ----------
  // register storage
  // ----------
  logic [7:0] setpoint_a_q; // first converter setpoint code
  logic [7:0] setpoint_b_q; // second converter setpoint code
  logic [7:0] stepup_ctrl_q; // step-up control byte
  logic [7:0] delay_a_q; // first converter off/on delay codes
  logic [7:0] delay_b_q; // second converter codes, stored only
  logic [2:0] first_ctrl_q; // first converter pin select and enable
  logic delay_scale_q; // global delay unit doubling
  logic otp_load_q; // high until defaults are copied in

  // ----------
  // apb decode
  // ----------
  wire [7:0] word_idx = PADDR_IN[9:2]; // byte address over four
  wire idx_high_zero = PADDR_IN[11:10] == 2'b00; // hits alias without it
  wire setup_phase = PSEL_IN && !PENABLE_IN; // first cycle of a transfer
  wire access_phase = PSEL_IN && PENABLE_IN; // completes with pready
  wire hit_setpoint_a = word_idx == rss_pkg::IDX_SETPOINT_A;
  wire hit_setpoint_b = word_idx == rss_pkg::IDX_SETPOINT_B;
  wire hit_stepup = word_idx == rss_pkg::IDX_STEPUP_CTRL;
  wire hit_delay_a = word_idx == rss_pkg::IDX_DELAY_A;
  wire hit_delay_b = word_idx == rss_pkg::IDX_DELAY_B;
  wire hit_first = word_idx == rss_pkg::IDX_FIRST_CTRL;
  wire hit_config = word_idx == rss_pkg::IDX_CONFIG;
  wire hit_status = word_idx == rss_pkg::IDX_STATUS;
  wire hit_any = hit_setpoint_a || hit_setpoint_b || hit_stepup || hit_delay_a
    || hit_delay_b || hit_first || hit_config || hit_status;
  // a misaligned byte address is treated as unmapped
  wire addr_ok = hit_any && idx_high_zero && (PADDR_IN[1:0] == 2'b00);
  // status is read-only, so a write there is refused as well
  wire access_ok = addr_ok && !(PWRITE_IN && hit_status);
  // writes land in the access cycle, low byte lane only
  wire wr_en = access_phase && PWRITE_IN && access_ok && PSTRB_IN[0] && PREADY_OUT;
  wire [7:0] wbyte = PWDATA_IN[7:0];

  // ----------
  // enable pin selection and control signals
  // ----------
  wire [3:0] pin_vec = {ENABLE_PIN_C_IN, ENABLE_PIN_B_IN, ENABLE_PIN_A_IN, 1'b1};
  wire [1:0] stepup_pin_sel = stepup_ctrl_q[rss_pkg::PIN_HI:rss_pkg::PIN_LO];
  wire [1:0] first_pin_sel = first_ctrl_q[rss_pkg::PIN_HI:rss_pkg::PIN_LO];
  // select 0 picks the constant one, so only the software bit counts
  wire stepup_on = stepup_ctrl_q[rss_pkg::EN_BIT] && pin_vec[stepup_pin_sel];
  // the sequencing control is the enable bit gated by its pin
  wire first_ctrl_level = first_ctrl_q[rss_pkg::EN_BIT] && pin_vec[first_pin_sel];

  // ----------
  // free-running delay time base
  // ----------
  // free-running and never restarted by the sequencer, so the first unit of a delay may be
  // shorter by up to one unit; that jitter is the price of one counter
  logic [15:0] unit_cnt_q; // cycles within the current unit
  logic unit_tick_q; // one-cycle pulse each 0.5 ms
  wire unit_wrap = unit_cnt_q == 16'(UNIT_CYCLES - 1);

  // unit counter, runs regardless of register traffic
  always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      unit_cnt_q <= 16'h0000;
      unit_tick_q <= 1'b0;
    end else begin
      unit_cnt_q <= unit_wrap ? 16'h0000 : unit_cnt_q + 16'h0001;
      unit_tick_q <= unit_wrap;
    end
  end

  // ----------
  // first converter sequencer
  // ----------
  logic first_enable; // sequenced enable level
  logic first_busy; // a delay is pending

  rss_delay_timer u_first_seq (
    .clk_in(MCLK_IN),
    .rst_n_in(RESET_N_IN),
    .tick_in(unit_tick_q),
    .ctrl_in(first_ctrl_level),
    .on_code_in(delay_a_q[rss_pkg::ON_HI:rss_pkg::ON_LO]),
    .off_code_in(delay_a_q[rss_pkg::OFF_HI:rss_pkg::OFF_LO]),
    .scale_in(delay_scale_q),
    .enable_out(first_enable),
    .busy_out(first_busy)
  );

  // ----------
  // setpoint code to millivolt mapping
  // ----------
  // reserved codes read back as zero millivolts; nothing is regulated
  function automatic logic [11:0] code_to_mv(input logic [7:0] code);
    logic [11:0] c;
    c = {4'h0, code};
    if (code < rss_pkg::CODE_BAND1) begin
      code_to_mv = 12'h000;
    end else if (code <= rss_pkg::CODE_BAND1_TOP) begin
      code_to_mv = 12'(rss_pkg::MV_BAND1
        + (c - {4'h0, rss_pkg::CODE_BAND1}) * rss_pkg::STEP_BAND1);
    end else if (code <= rss_pkg::CODE_BAND2_TOP) begin
      code_to_mv = 12'(rss_pkg::MV_BAND2
        + (c - {4'h0, rss_pkg::CODE_BAND2}) * rss_pkg::STEP_BAND2);
    end else begin
      code_to_mv = 12'(rss_pkg::MV_BAND3
        + (c - {4'h0, rss_pkg::CODE_BAND3}) * rss_pkg::STEP_BAND3);
    end
  endfunction

  wire [11:0] mv_a = code_to_mv(setpoint_a_q);
  wire [11:0] mv_b = code_to_mv(setpoint_b_q);
  wire [1:0] stepup_vsel = stepup_ctrl_q[rss_pkg::VSEL_HI:rss_pkg::VSEL_LO];
  wire [12:0] mv_stepup = 13'(rss_pkg::MV_STEPUP_BASE
    + {11'h000, stepup_vsel} * rss_pkg::MV_STEPUP_STEP);
  // discharge only while the converter is off
  wire stepup_dis = !stepup_on && stepup_ctrl_q[rss_pkg::RDIS_BIT];
  wire first_dis = !first_enable;

  // ----------
  // read mux
  // ----------
  wire [7:0] status_byte = {2'b00, first_busy, ENABLE_PIN_C_IN, ENABLE_PIN_B_IN,
    ENABLE_PIN_A_IN, first_enable, stepup_on};
  wire [7:0] rd_byte = hit_setpoint_a ? setpoint_a_q :
    hit_setpoint_b ? setpoint_b_q :
    hit_stepup ? stepup_ctrl_q :
    hit_delay_a ? delay_a_q :
    hit_delay_b ? delay_b_q :
    hit_first ? {5'h00, first_ctrl_q} :
    hit_config ? {7'h00, delay_scale_q} :
    hit_status ? status_byte : rss_pkg::RST_ZERO;

  // ----------
  // apb answer flops
  // ----------
  // read data and error are captured in the setup cycle so that
  // they stand as flop outputs for the whole access cycle
  always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      PRDATA_OUT <= 32'h00000000;
      PSLVERR_OUT <= 1'b0;
      PREADY_OUT <= 1'b0;
    end else begin
      PREADY_OUT <= 1'b1; // zero wait states once out of reset
      if (setup_phase) begin
        PRDATA_OUT <= (!PWRITE_IN && addr_ok) ? {24'h000000, rd_byte} : 32'h00000000;
        PSLVERR_OUT <= !access_ok;
      end
    end
  end

  // ----------
  // software registers
  // ----------
  // async reset takes fixed constants; the first clock after release
  // copies in the programmed defaults, so a strap is never reset-sampled
  always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      otp_load_q <= 1'b1;
      setpoint_a_q <= rss_pkg::RST_SETPOINT;
      setpoint_b_q <= rss_pkg::RST_SETPOINT;
      stepup_ctrl_q <= rss_pkg::RST_STEPUP_CTRL;
      delay_a_q <= rss_pkg::RST_DELAY;
      delay_b_q <= rss_pkg::RST_DELAY;
      first_ctrl_q <= 3'h0;
      delay_scale_q <= 1'b0;
    end else if (otp_load_q) begin
      otp_load_q <= 1'b0;
      setpoint_a_q <= OTP_SETPOINT_A_IN;
      setpoint_b_q <= OTP_SETPOINT_B_IN;
      // reserved and discharge bits keep their fixed reset value
      stepup_ctrl_q <= {OTP_STEPUP_VSEL_IN, rss_pkg::RST_STEPUP_CTRL[5:3],
        OTP_STEPUP_PIN_IN, OTP_STEPUP_EN_IN};
      delay_a_q <= OTP_DELAY_A_IN;
      delay_b_q <= OTP_DELAY_B_IN;
      first_ctrl_q <= OTP_FIRST_CTRL_IN;
      delay_scale_q <= OTP_DELAY_SCALE_IN;
    end else if (wr_en) begin
      if (hit_setpoint_a) begin
        setpoint_a_q <= wbyte;
      end
      if (hit_setpoint_b) begin
        setpoint_b_q <= wbyte;
      end
      if (hit_stepup) begin
        stepup_ctrl_q <= wbyte;
      end
      if (hit_delay_a) begin
        delay_a_q <= wbyte;
      end
      if (hit_delay_b) begin
        delay_b_q <= wbyte;
      end
      if (hit_first) begin
        first_ctrl_q <= wbyte[2:0];
      end
      if (hit_config) begin
        delay_scale_q <= wbyte[0];
      end
    end
  end

  // ----------
  // converter control outputs
  // ----------
  // all converter outputs are flopped, adding one cycle of latency
  always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      FIRST_STEPDOWN_SETPOINT_OUT <= rss_pkg::RST_SETPOINT;
      SECOND_STEPDOWN_SETPOINT_OUT <= rss_pkg::RST_SETPOINT;
      FIRST_STEPDOWN_MV_OUT <= 12'h000;
      SECOND_STEPDOWN_MV_OUT <= 12'h000;
      STEPUP_MV_OUT <= 13'h0000;
      STEPUP_ENABLE_OUT <= 1'b0;
      STEPUP_DISCHARGE_OUT <= 1'b0;
      FIRST_STEPDOWN_ENABLE_OUT <= 1'b0;
      FIRST_STEPDOWN_DISCHARGE_OUT <= 1'b0;
    end else begin
      FIRST_STEPDOWN_SETPOINT_OUT <= setpoint_a_q;
      SECOND_STEPDOWN_SETPOINT_OUT <= setpoint_b_q;
      FIRST_STEPDOWN_MV_OUT <= mv_a;
      SECOND_STEPDOWN_MV_OUT <= mv_b;
      STEPUP_MV_OUT <= mv_stepup;
      STEPUP_ENABLE_OUT <= stepup_on;
      STEPUP_DISCHARGE_OUT <= stepup_dis;
      FIRST_STEPDOWN_ENABLE_OUT <= first_enable;
      FIRST_STEPDOWN_DISCHARGE_OUT <= first_dis;
    end
  end
endmodule
`default_nettype wire

// File: testbench/rss_top_sva.sv
// assertion checker for the setpoint and sequencing register block
`timescale 1ns/1ps
`default_nettype none
module rss_top_sva (
  input wire logic MCLK_IN,
  input wire logic RESET_N_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  input wire logic [3:0] PSTRB_IN,
  input wire logic [31:0] PRDATA_OUT,
  input wire logic PREADY_OUT,
  input wire logic PSLVERR_OUT,
  input wire logic [7:0] FIRST_STEPDOWN_SETPOINT_OUT,
  input wire logic [7:0] SECOND_STEPDOWN_SETPOINT_OUT,
  input wire logic [11:0] FIRST_STEPDOWN_MV_OUT,
  input wire logic [11:0] SECOND_STEPDOWN_MV_OUT,
  input wire logic [12:0] STEPUP_MV_OUT,
  input wire logic STEPUP_ENABLE_OUT,
  input wire logic STEPUP_DISCHARGE_OUT,
  input wire logic FIRST_STEPDOWN_ENABLE_OUT,
  input wire logic FIRST_STEPDOWN_DISCHARGE_OUT
);
  // ----------
  // helpers
  // ----------
  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (!RESET_N_IN);
  // a completed write with the low byte strobed
  wire logic wr_done;
  assign wr_done = PSEL_IN && PENABLE_IN && PWRITE_IN && PREADY_OUT && PSTRB_IN[0];
  // target millivolts of a code; reserved codes read as zero
  function automatic logic [11:0] mv(input logic [7:0] c);
    if (c < rss_pkg::CODE_BAND1) return 12'h000;
    if (c < rss_pkg::CODE_BAND2) return rss_pkg::MV_BAND1 + rss_pkg::STEP_BAND1 * (c - 8'h14);
    if (c < rss_pkg::CODE_BAND3) return rss_pkg::MV_BAND2 + rss_pkg::STEP_BAND2 * (c - 8'h18);
    return rss_pkg::MV_BAND3 + rss_pkg::STEP_BAND3 * (c - 8'h9e);
  endfunction
  // ----------
  // assertions
  // ----------
  chk_setpoint_copy: assert property (
    wr_done && PADDR_IN == 12'h018 |-> ##2
    FIRST_STEPDOWN_SETPOINT_OUT == 8'($past(PWDATA_IN, 2)))
    else $error("setpoint output missed a write");
  chk_stepup_volts: assert property (
    wr_done && PADDR_IN == 12'h020 |-> ##2
    STEPUP_MV_OUT == 13'(13'h1324 + 13'h064 * (($past(PWDATA_IN, 2) >> 6) & 3)))
    else $error("step-up voltage does not follow its field");
  chk_first_map: assert property (FIRST_STEPDOWN_MV_OUT == mv(FIRST_STEPDOWN_SETPOINT_OUT))
    else $error("first converter voltage does not match code");
  chk_second_map: assert property (SECOND_STEPDOWN_MV_OUT == mv(SECOND_STEPDOWN_SETPOINT_OUT))
    else $error("second converter voltage does not match code");
  chk_stepup_discharge: assert property (STEPUP_ENABLE_OUT |-> !STEPUP_DISCHARGE_OUT)
    else $error("discharge connected while step-up runs");
  chk_first_discharge: assert property (
    $past(RESET_N_IN) |-> FIRST_STEPDOWN_DISCHARGE_OUT != FIRST_STEPDOWN_ENABLE_OUT)
    else $error("first discharge is not the inverse of its enable");
  chk_ready_high: assert property ($past(RESET_N_IN) |-> PREADY_OUT)
    else $error("ready low outside reset");
  chk_misaligned_err: assert property (
    PSEL_IN && !PENABLE_IN && PADDR_IN[1:0] != 2'b00 |=> PSLVERR_OUT && PRDATA_OUT == 32'h0)
    else $error("misaligned access not refused");
  // main scenarios reached
  cov_first_on: cover property ($rose(FIRST_STEPDOWN_ENABLE_OUT));
  cov_stepup_on: cover property ($rose(STEPUP_ENABLE_OUT));
  cov_refused: cover property (PSLVERR_OUT && PENABLE_IN);
endmodule
`default_nettype wire

// File: testbench/rss_top_test.sv
// self-checking bench for the setpoint and sequencing register block
`timescale 1ns/1ps
`default_nettype none
module rss_top_test;
  // ----------
  // signals
  // ----------
  localparam int U = 8; // short delay unit keeps the run brief
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic [2:0] pins = 3'h0; // pins c, b, a
  logic [7:0] otp_a, otp_b, otp_da, otp_db;
  logic [2:0] otp_fc;
  logic [1:0] otp_v, otp_p;
  logic otp_en, otp_sc, pready, pslverr, su_en, su_dis, f_en, f_dis;
  logic [31:0] prdata;
  logic [7:0] sp_a, sp_b;
  logic [11:0] mv_a, mv_b;
  logic [12:0] su_mv;
  logic [32:0] notes[$]; // expected {error, read data}
  int fails = 0;
  int check_count = 0;
  always #12.5 mclk = ~mclk;
  rss_top #(.UNIT_CYCLES(U)) dut (
    .MCLK_IN(mclk), .RESET_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
    .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PSTRB_IN(pstrb), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .ENABLE_PIN_A_IN(pins[0]),
    .ENABLE_PIN_B_IN(pins[1]), .ENABLE_PIN_C_IN(pins[2]), .OTP_SETPOINT_A_IN(otp_a),
    .OTP_SETPOINT_B_IN(otp_b), .OTP_STEPUP_VSEL_IN(otp_v), .OTP_STEPUP_PIN_IN(otp_p),
    .OTP_STEPUP_EN_IN(otp_en), .OTP_FIRST_CTRL_IN(otp_fc), .OTP_DELAY_A_IN(otp_da),
    .OTP_DELAY_B_IN(otp_db), .OTP_DELAY_SCALE_IN(otp_sc), .FIRST_STEPDOWN_SETPOINT_OUT(sp_a),
    .SECOND_STEPDOWN_SETPOINT_OUT(sp_b), .FIRST_STEPDOWN_MV_OUT(mv_a),
    .SECOND_STEPDOWN_MV_OUT(mv_b), .STEPUP_MV_OUT(su_mv), .STEPUP_ENABLE_OUT(su_en),
    .STEPUP_DISCHARGE_OUT(su_dis), .FIRST_STEPDOWN_ENABLE_OUT(f_en),
    .FIRST_STEPDOWN_DISCHARGE_OUT(f_dis));
  // ----------
  // tasks
  // ----------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [11:0] exp_mv(input logic [7:0] c);
    if (c < 8'h14) return 12'h000;
    if (c < 8'h18) return rss_pkg::MV_BAND1 + rss_pkg::STEP_BAND1 * (c - 8'h14);
    if (c < 8'h9e) return rss_pkg::MV_BAND2 + rss_pkg::STEP_BAND2 * (c - 8'h18);
    return rss_pkg::MV_BAND3 + rss_pkg::STEP_BAND3 * (c - 8'h9e);
  endfunction
  // one apb transfer; a read leaves its expectation for the monitor
  task automatic apb(input logic w, input logic [7:0] idx, input logic [1:0] lo,
      input logic [7:0] d, input logic [3:0] s, input logic [32:0] exp);
    @(posedge mclk);
    if (!w) notes.push_back(exp);
    psel <= 1'b1;
    pwr <= w;
    paddr <= {2'b00, idx, lo};
    pwdata <= {24'h0, d};
    pstrb <= s;
    @(posedge mclk);
    pen <= 1'b1;
    // no limit of its own: only the watchdog ends this wait
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, 2'b00, d, 4'h1, 33'h0);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b0, idx, 2'b00, 8'h00, 4'h0, {25'h0, d});
  endtask
  // counts edges until the first converter's enable reaches a level
  task automatic wait_en(input logic v, output int n);
    n = 0;
    while (f_en !== v && n < 600) begin
      @(posedge mclk);
      n++;
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ----------
  // read monitor and watchdog
  // ----------
  always @(posedge mclk) begin
    if (psel && pen && !pwr && pready === 1'b1 && notes.size() > 0) begin
      check("read data", prdata, notes[0][31:0]);
      check("read error", pslverr, notes[0][32]);
      void'(notes.pop_front());
    end
  end
  initial begin
    #(25ns * 20000);
    fails++;
    close_out();
  end
  // ----------
  // main sequence
  // ----------
  initial begin
    int n, lo, hi;
    logic [7:0] c;
    logic [31:0] r;
    logic [7:0] codes[8] = '{8'h80, 8'h14, 8'h17, 8'h18, 8'h9d, 8'h9e, 8'hff, 8'h60};
    int dk[5] = '{0, 1, 15, 3, 15};
    int ds[5] = '{0, 0, 0, 1, 1};
    void'($urandom(61829));
    {otp_a, otp_b, otp_da, otp_db} = $urandom;
    {otp_fc, otp_v, otp_p, otp_en, otp_sc} = 9'($urandom);
    codes[7] = 8'h14 + 8'($urandom % 236);
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (2) @(posedge mclk);
    // defaults after reset, reserved bits fixed, refused places
    rd(rss_pkg::IDX_SETPOINT_A, otp_a);
    rd(rss_pkg::IDX_SETPOINT_B, otp_b);
    rd(rss_pkg::IDX_STEPUP_CTRL, {otp_v, 3'b001, otp_p, otp_en});
    rd(rss_pkg::IDX_DELAY_A, otp_da);
    rd(rss_pkg::IDX_DELAY_B, otp_db);
    apb(1'b0, 8'h05, 2'b00, 8'h00, 4'h0, {1'b1, 32'h0});
    apb(1'b0, rss_pkg::IDX_DELAY_A, 2'b10, 8'h00, 4'h0, {1'b1, 32'h0});
    apb(1'b1, rss_pkg::IDX_DELAY_B, 2'b00, 8'h5a, 4'he, 33'h0);
    rd(rss_pkg::IDX_DELAY_B, otp_db);
    // band edges on both converters; reserved codes are never written
    foreach (codes[i]) begin
      wr(rss_pkg::IDX_SETPOINT_A, codes[i]);
      wr(rss_pkg::IDX_SETPOINT_B, codes[(i + 1) % 8]);
      repeat (2) @(posedge mclk);
      check("first mv", mv_a, exp_mv(codes[i]));
      check("second mv", mv_b, exp_mv(codes[(i + 1) % 8]));
      rd(rss_pkg::IDX_SETPOINT_A, codes[i]);
    end
    // every voltage and pin-gating code with random pins and bits
    for (int i = 0; i < 16; i++) begin
      r = $urandom;
      c = {2'(i), 2'b01, r[0], 2'(i >> 2), r[1]};
      pins <= r[4:2];
      wr(rss_pkg::IDX_STEPUP_CTRL, c);
      repeat (2) @(posedge mclk);
      n = (c[2:1] == 2'b00) ? 1 : int'(pins[c[2:1] - 2'b01]);
      check("stepup mv", su_mv, rss_pkg::MV_STEPUP_BASE + rss_pkg::MV_STEPUP_STEP * c[7:6]);
      check("stepup enable", su_en, c[0] & n[0]);
      check("stepup discharge", su_dis, c[3] & ~(c[0] & n[0]));
      rd(rss_pkg::IDX_STEPUP_CTRL, c);
    end
    // startup and shutdown delays at both scales
    wr(rss_pkg::IDX_FIRST_CTRL, 8'h00);
    wr(rss_pkg::IDX_DELAY_A, 8'h00);
    wait_en(1'b0, n);
    foreach (dk[i]) begin
      wr(rss_pkg::IDX_CONFIG, 8'(ds[i]));
      wr(rss_pkg::IDX_DELAY_A, {4'(dk[i]), 4'(dk[i])});
      hi = dk[i] * (ds[i] + 1) * U + 4;
      lo = (dk[i] == 0) ? 0 : (dk[i] * (ds[i] + 1) - 1) * U;
      wr(rss_pkg::IDX_FIRST_CTRL, 8'h01);
      wait_en(1'b1, n);
      check("startup delay", n >= lo && n <= hi, 1);
      wr(rss_pkg::IDX_FIRST_CTRL, 8'h00);
      wait_en(1'b0, n);
      check("shutdown delay", n >= lo && n <= hi, 1);
    end
    // a reversal cancels a pending start; pin a then gates the start
    wr(rss_pkg::IDX_DELAY_A, 8'h04);
    wr(rss_pkg::IDX_FIRST_CTRL, 8'h01);
    wr(rss_pkg::IDX_FIRST_CTRL, 8'h00);
    // scale is still doubled: code 4 is eight units, so wait past them
    repeat (10 * U) @(posedge mclk);
    check("cancelled start", f_en, 1'b0);
    pins <= 3'b000;
    wr(rss_pkg::IDX_FIRST_CTRL, 8'h03);
    repeat (10 * U) @(posedge mclk);
    check("start held by pin", f_en, 1'b0);
    pins <= 3'b001;
    wait_en(1'b1, n);
    check("start after pin", n >= 7 * U && n <= 8 * U + 4, 1);
    close_out();
  end
endmodule
bind rss_top rss_top_sva u_sva (.MCLK_IN, .RESET_N_IN, .PSEL_IN, .PENABLE_IN, .PWRITE_IN,
  .PADDR_IN, .PWDATA_IN, .PSTRB_IN, .PRDATA_OUT, .PREADY_OUT, .PSLVERR_OUT,
  .FIRST_STEPDOWN_SETPOINT_OUT, .SECOND_STEPDOWN_SETPOINT_OUT, .FIRST_STEPDOWN_MV_OUT,
  .SECOND_STEPDOWN_MV_OUT, .STEPUP_MV_OUT, .STEPUP_ENABLE_OUT, .STEPUP_DISCHARGE_OUT,
  .FIRST_STEPDOWN_ENABLE_OUT, .FIRST_STEPDOWN_DISCHARGE_OUT);
`default_nettype wire
